// ### hw/gateway_status_control_handshake.sv
// Status and control word block with startup data-exchange gating.
//
// Summary of operation
// - Words absent unless configuration enables them
// - Status at input 0x000, control at 0x200
// - Words stored most-significant byte first
// - Both sides follow the defined handshake sequence
// - Startup lock withholds exchange until control valid
// - Without lock, exchange starts once fieldbus online
// - Exchange both ways until gateway goes offline
// - Gateway never clears status valid by itself
// - Status valid may be delayed by missing nodes
// - Bit 13 sets after all transactions outside generic data mode, sticks
// - Bits 15 and 14 carry send/confirm toggles
// - Bits 12..8 last status code, low byte data
`timescale 1ns/1ps
module gateway_status_control_handshake
    import gw_handshake_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Configuration.
    input wire logic [1:0] word_mode_i,
    input wire logic generic_data_mode_i,
    // Fieldbus side byte access to the data areas.
    input wire logic fb_online_i,
    input wire logic [9:0] fb_addr_i,
    input wire logic fb_wr_i,
    input wire logic [7:0] fb_wdata_i,
    output logic [7:0] fb_rdata_o,
    output logic fb_hit_o,
    // Subnetwork engine side.
    input wire logic all_transactions_done_i,
    input wire logic status_report_i,
    input wire logic [4:0] status_code_i,
    input wire logic [7:0] status_data_i,
    input wire logic send_toggle_i,
    input wire logic confirm_toggle_i,
    output logic [15:0] host_control_word_o,
    output logic exchange_enable_o,
    output logic [1:0] link_state_o
);
    logic online_meta_r;
    logic online_sync_r;
    logic [15:0] control_r;
    logic [15:0] control_nxt;
    logic data_valid_r;
    logic data_valid_nxt;
    logic [4:0] code_r;
    logic [4:0] code_nxt;
    logic [7:0] sdata_r;
    logic [7:0] sdata_nxt;
    logic [1:0] toggles_r;
    link_state_t state_r;
    link_state_t state_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic words_on;
    logic lock_on;
    logic [15:0] status_word;
    logic host_valid;

    // The fieldbus online level is asynchronous to this clock.
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            online_meta_r <= 1'b0;
            online_sync_r <= 1'b0;
        end else begin
            online_meta_r <= fb_online_i;
            online_sync_r <= online_meta_r;
        end
    end

    assign words_on = (word_mode_i != WORDS_DISABLED);
    assign lock_on = (word_mode_i == WORDS_ENABLED_LOCK);
    assign host_valid = control_r[CTRL_DATA_VALID_BIT];

    assign status_word = {toggles_r, data_valid_r, code_r, sdata_r};

    // Control word writes; byte 0 is the upper byte.
    always_comb begin
        control_nxt = control_r;
        if (words_on && fb_wr_i) begin
            if (fb_addr_i == CONTROL_WORD_OFFSET) begin
                control_nxt[15:8] = fb_wdata_i;
            end else if (fb_addr_i == CONTROL_WORD_OFFSET + 10'h001) begin
                control_nxt[7:0] = fb_wdata_i;
            end
        end
    end

    // Status fields. The data valid flag is sticky: nothing here clears it.
    always_comb begin
        data_valid_nxt = data_valid_r;
        code_nxt = code_r;
        sdata_nxt = sdata_r;
        if (!generic_data_mode_i && all_transactions_done_i) begin
            data_valid_nxt = 1'b1;
        end
        if (status_report_i) begin
            code_nxt = status_code_i;
            sdata_nxt = status_data_i;
        end
    end

    // Participation state follows the gateway's own view of the handshake.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_OFFLINE: begin
                if (online_sync_r) begin
                    state_nxt = ST_ONLINE_WAIT;
                end
            end
            ST_ONLINE_WAIT: begin
                if (!online_sync_r) begin
                    state_nxt = ST_OFFLINE;
                end else if (!lock_on || host_valid) begin
                    state_nxt = ST_EXCHANGE;
                end
            end
            ST_EXCHANGE: begin
                if (!online_sync_r) begin
                    state_nxt = ST_OFFLINE;
                end
            end
            default: state_nxt = ST_OFFLINE;
        endcase
    end

    // Byte read data, upper byte at the lower address.
    always_comb begin
        rdata_nxt = 8'h00;
        if (words_on) begin
            if (fb_addr_i == STATUS_WORD_OFFSET) begin
                rdata_nxt = status_word[15:8];
            end else if (fb_addr_i == STATUS_WORD_OFFSET + 10'h001) begin
                rdata_nxt = status_word[7:0];
            end else if (fb_addr_i == CONTROL_WORD_OFFSET) begin
                rdata_nxt = control_r[15:8];
            end else if (fb_addr_i == CONTROL_WORD_OFFSET + 10'h001) begin
                rdata_nxt = control_r[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            control_r <= CONTROL_WORD_RESET;
            data_valid_r <= 1'b0;
            code_r <= CODE_NO_ERROR;
            sdata_r <= STATUS_DATA_RESET;
            toggles_r <= 2'b00;
            state_r <= ST_OFFLINE;
            rdata_r <= 8'h00;
        end else begin
            control_r <= control_nxt;
            data_valid_r <= data_valid_nxt;
            code_r <= code_nxt;
            sdata_r <= sdata_nxt;
            toggles_r <= {send_toggle_i, confirm_toggle_i};
            state_r <= state_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Addresses inside the word areas are claimed only while enabled; the
    // surrounding data path serves everything else as ordinary I/O data.
    assign fb_hit_o = words_on &&
        (fb_addr_i[9:1] == STATUS_WORD_OFFSET[9:1] ||
         fb_addr_i[9:1] == CONTROL_WORD_OFFSET[9:1]);
    assign fb_rdata_o = rdata_r;
    assign host_control_word_o = control_r;
    assign exchange_enable_o = (state_r == ST_EXCHANGE);
    assign link_state_o = state_r;

    // Assertions. Each watches what this module drives. Those that look across an
    // edge, except AST_OFFLINE_NO_EXCH, AST_OFFLINE_DROP, AST_GENERIC_NO_VALID and
    // AST_HIDDEN, also ask for reset to be released already, so that a reset held for a
    // single edge cannot trip them at the edge on which it is released.
    sequence host_valid_seen;
        host_valid && online_sync_r;
    endsequence

    sequence lock_release_seen;
        (reset_n_i && state_r == ST_ONLINE_WAIT && lock_on) and host_valid_seen;
    endsequence

    // Offline with the link up, then still up and unlocked one cycle later.
    sequence online_entry_seen;
        (reset_n_i && !lock_on && online_sync_r && state_r == ST_OFFLINE)
        ##1 (!lock_on && online_sync_r);
    endsequence

    // Startup gating.
    AST_LOCK_HOLDS: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reset_n_i && lock_on && !host_valid && state_r != ST_EXCHANGE)
        |=> !exchange_enable_o)
        else $error("Exchange started without host data valid.");
    AST_LOCK_RELEASE: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        lock_release_seen
        |=> exchange_enable_o)
        else $error("Exchange not started after host data valid.");
    AST_NO_LOCK_START: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        online_entry_seen
        |=> exchange_enable_o)
        else $error("Exchange not started two cycles after online.");
    AST_ONLINE_ENTER: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reset_n_i && state_r == ST_OFFLINE && online_sync_r)
        |=> state_r == ST_ONLINE_WAIT)
        else $error("Online wait not entered after fieldbus online.");
    AST_OFFLINE_NO_EXCH: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (state_r == ST_OFFLINE)
        |=> !exchange_enable_o)
        else $error("Exchange started straight from offline.");
    // Return to offline, and staying in exchange while online.
    AST_OFFLINE_DROP: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (!online_sync_r)
        |=> state_r == ST_OFFLINE)
        else $error("State did not return to offline.");
    AST_EXCHANGE_HOLDS: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reset_n_i && state_r == ST_EXCHANGE && online_sync_r)
        |=> exchange_enable_o)
        else $error("Exchange dropped while fieldbus online.");
    // Reset values, then status word fields.
    AST_RESET_STATE: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        $rose(reset_n_i)
        |-> (!data_valid_r && state_r == ST_OFFLINE && control_r == CONTROL_WORD_RESET))
        else $error("Status valid or state not cleared by reset.");
    AST_VALID_STICKY: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reset_n_i && data_valid_r)
        |=> data_valid_r)
        else $error("Status data valid cleared.");
    AST_VALID_SET: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reset_n_i && !generic_data_mode_i && all_transactions_done_i)
        |=> status_word[DATA_VALID_BIT])
        else $error("Status data valid not set.");
    AST_GENERIC_NO_VALID: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (generic_data_mode_i && !data_valid_r)
        |=> !status_word[DATA_VALID_BIT])
        else $error("Status data valid set in generic data mode.");
    AST_CODE_LOAD: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reset_n_i && status_report_i)
        |=> status_word[CODE_HI_BIT:CODE_LO_BIT] == $past(status_code_i))
        else $error("Status code not loaded.");
    AST_REPORT_DATA: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reset_n_i && status_report_i)
        |=> status_word[CODE_LO_BIT-1:0] == $past(status_data_i))
        else $error("Status data byte not loaded.");
    AST_CODE_HOLDS: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reset_n_i && !status_report_i)
        |=> status_word[CODE_HI_BIT:0] == $past(status_word[CODE_HI_BIT:0]))
        else $error("Status report changed without a report.");
    AST_TOGGLES: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        reset_n_i
        |=> status_word[SEND_TOGGLE_BIT] == $past(send_toggle_i) &&
            status_word[CONFIRM_TOGGLE_BIT] == $past(confirm_toggle_i))
        else $error("Handshake toggles not reflected.");
    // Fieldbus byte access.
    AST_HIDDEN: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (!words_on)
        |-> !fb_hit_o ##1 fb_rdata_o == 8'h00)
        else $error("Words visible while disabled.");
    AST_CTRL_UPPER_WR: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reset_n_i && words_on && fb_wr_i && fb_addr_i == CONTROL_WORD_OFFSET)
        |=> control_r[15:8] == $past(fb_wdata_i))
        else $error("Control word upper byte not written.");
    AST_CTRL_LOWER_WR: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reset_n_i && words_on && fb_wr_i && fb_addr_i == CONTROL_WORD_OFFSET + 10'h001)
        |=> control_r[7:0] == $past(fb_wdata_i))
        else $error("Control word lower byte not written.");
    AST_CTRL_REFUSED: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reset_n_i && (!words_on || !fb_wr_i || fb_addr_i[9:1] != CONTROL_WORD_OFFSET[9:1]))
        |=> control_r == $past(control_r))
        else $error("Control word changed by a refused write.");
    AST_MSB_FIRST: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reset_n_i && words_on && !fb_wr_i && fb_addr_i == CONTROL_WORD_OFFSET)
        |=> fb_rdata_o == $past(control_r[15:8]))
        else $error("Control word upper byte not first.");
    AST_STATUS_UPPER_RD: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reset_n_i && words_on && fb_addr_i == STATUS_WORD_OFFSET)
        |=> fb_rdata_o == $past(status_word[15:8]))
        else $error("Status word upper byte not at the lower address.");
    AST_STATUS_LOWER_RD: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        (reset_n_i && words_on && fb_addr_i == STATUS_WORD_OFFSET + 10'h001)
        |=> fb_rdata_o == $past(status_word[7:0]))
        else $error("Status word lower byte not at the upper address.");
endmodule

// ### hw/gw_handshake_pkg.sv
// Package with offsets, field positions and modes of the status/control word block.
package gw_handshake_pkg;
    localparam logic [9:0] STATUS_WORD_OFFSET = 10'h000;
    localparam logic [9:0] CONTROL_WORD_OFFSET = 10'h200;
    localparam int SEND_TOGGLE_BIT = 15;
    localparam int CONFIRM_TOGGLE_BIT = 14;
    localparam int DATA_VALID_BIT = 13;
    localparam int CODE_HI_BIT = 12;
    localparam int CODE_LO_BIT = 8;
    localparam int CTRL_DATA_VALID_BIT = 13;
    localparam logic [4:0] CODE_NO_ERROR = 5'h1f;
    localparam logic [15:0] CONTROL_WORD_RESET = 16'h0000;
    localparam logic [7:0] STATUS_DATA_RESET = 8'h00;
    // Word enable configuration.
    typedef enum logic [1:0] {
        WORDS_DISABLED = 2'h0,
        WORDS_ENABLED_LOCK = 2'h1,
        WORDS_ENABLED_NO_LOCK = 2'h3
    } word_mode_t;
    // Gray coded along the usual offline, online, exchanging path.
    typedef enum logic [1:0] {
        ST_OFFLINE = 2'h0,
        ST_ONLINE_WAIT = 2'h1,
        ST_EXCHANGE = 2'h3
    } link_state_t;
endpackage

// ### test/fb_host_model.sv
// Fieldbus master model with byte access to the data areas.
`timescale 1ns/1ps
module fb_host_model (
    // Clock.
    input wire logic clk_sys_i,
    // Data area access.
    input wire logic [7:0] fb_rdata_i,
    output logic [9:0] fb_addr_o,
    output logic fb_wr_o,
    output logic [7:0] fb_wdata_o
);
    initial begin
        fb_addr_o = 10'h3ff;
        fb_wr_o = 1'b0;
        fb_wdata_o = 8'h00;
    end
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        fb_addr_o <= a;
        fb_wr_o <= 1'b1;
        fb_wdata_o <= d;
        @(posedge clk_sys_i);
        fb_wr_o <= 1'b0;
        fb_wdata_o <= ~d;
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        fb_addr_o <= a;
        @(posedge clk_sys_i);
        #1 d = fb_rdata_i;
    endtask
    // Own valid is set only after the gateway's valid was seen clear.
    task automatic start(output logic [7:0] st);
        wr(10'h200, 8'h00);
        rd(10'h000, st);
        if (st[5] === 1'b0) wr(10'h200, 8'h20);
    endtask
endmodule

// ### test/testbench.sv
// Self-checking bench for the status and control word block.
`timescale 1ns/1ps
module testbench;
    import gw_handshake_pkg::*;
    logic clk_sys_i, reset_n_i, gen, online, done, rep, snd, cnf, wr, hit, exch;
    logic [1:0] mode, st;
    logic [4:0] code;
    logic [7:0] sdat, rdata, wdata, b;
    logic [9:0] addr;
    logic [15:0] ctrl;
    logic [31:0] lfsr = 32'h43a7535b;
    int fails = 0;
    int comparisons = 0;
    gateway_status_control_handshake uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
        .word_mode_i(mode), .generic_data_mode_i(gen), .fb_online_i(online),
        .fb_addr_i(addr), .fb_wr_i(wr), .fb_wdata_i(wdata), .fb_rdata_o(rdata),
        .fb_hit_o(hit), .all_transactions_done_i(done), .status_report_i(rep),
        .status_code_i(code), .status_data_i(sdat), .send_toggle_i(snd),
        .confirm_toggle_i(cnf), .host_control_word_o(ctrl), .exchange_enable_o(exch),
        .link_state_o(st));
    fb_host_model host (.clk_sys_i(clk_sys_i), .fb_rdata_i(rdata), .fb_addr_o(addr),
        .fb_wr_o(wr), .fb_wdata_o(wdata));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Wide enough for the state, flag and word concatenations compared below.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Bounded wait, so a stuck state machine shows as a mismatch, not a hang.
    task automatic await(input logic [1:0] s);
        for (int n = 0; n < 20 && st !== s; n++) begin
            @(posedge clk_sys_i);
            #1;
        end
    endtask
    task automatic restart(input logic [1:0] m, input logic g, input int n);
        @(posedge clk_sys_i);
        reset_n_i <= 1'b0;
        mode <= m;
        gen <= g;
        online <= 1'b0;
        repeat (n) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
    endtask
    task automatic pulse_done;
        @(posedge clk_sys_i);
        done <= 1'b1;
        @(posedge clk_sys_i);
        done <= 1'b0;
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #40000;
        fails++;
        tally_and_finish();
    end
    initial begin
        {reset_n_i, gen, online, done, rep, snd, cnf, code, sdat} = '0;
        mode = WORDS_ENABLED_LOCK;
        restart(WORDS_ENABLED_LOCK, 1'b0, 10);
        #1 check({st, exch, ctrl}, 19'h0);
        host.rd(10'h000, b);
        check(b, 8'h1f);
        host.rd(10'h001, b);
        check({hit, b}, 9'h100);
        online <= 1'b1;
        await(ST_ONLINE_WAIT);
        repeat (6) @(posedge clk_sys_i);
        #1 check({st, exch}, {ST_ONLINE_WAIT, 1'b0});
        host.start(b);
        check(b, 8'h1f);
        await(ST_EXCHANGE);
        check({st, exch, ctrl}, {ST_EXCHANGE, 1'b1, 16'h2000});
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            host.wr(10'h201, lfsr[7:0]);
            #1 check(ctrl, {8'h20, lfsr[7:0]});
            @(posedge clk_sys_i);
            {rep, code, sdat, snd, cnf} <= {1'b1, lfsr[12:8], lfsr[23:16], lfsr[25:24]};
            @(posedge clk_sys_i);
            rep <= 1'b0;
            host.wr(10'h001, ~lfsr[23:16]);
            host.rd(10'h001, b);
            check(b, lfsr[23:16]);
            host.rd(10'h000, b);
            check(b, {lfsr[25:24], 1'b0, lfsr[12:8]});
            host.rd(10'h201, b);
            check(b, lfsr[7:0]);
        end
        pulse_done();
        host.rd(10'h000, b);
        check(b[5], 1'b1);
        online <= 1'b0;
        await(ST_OFFLINE);
        check({st, exch}, {ST_OFFLINE, 1'b0});
        host.rd(10'h000, b);
        check(b[5], 1'b1);
        restart(WORDS_ENABLED_NO_LOCK, 1'b1, 3);
        pulse_done();
        host.rd(10'h000, b);
        check(b[5], 1'b0);
        online <= 1'b1;
        await(ST_EXCHANGE);
        check({st, exch}, {ST_EXCHANGE, 1'b1});
        restart(WORDS_DISABLED, 1'b0, 3);
        online <= 1'b1;
        await(ST_EXCHANGE);
        check({st, exch}, {ST_EXCHANGE, 1'b1});
        host.wr(10'h200, 8'hff);
        host.rd(10'h000, b);
        check({hit, ctrl, b}, 25'h0);
        tally_and_finish();
    end
endmodule
